// ===== rtl/fec_flash_erase_ctrl.sv
// flash erase controller: apb registers, timing generator, erase sequencer
// =========================================================
// Notes on behaviour
// RQ1 - info: four 64-byte segments; main: 512-byte
// RQ2 - segment smallest erase unit; bit writes allowed
// RQ3 - lock set: first info segment protected
// RQ4 - lock clear: first segment acts normally
// RQ5 - writing one toggles lock; zero no effect
// RQ6 - idle: read mode, generators off
// RQ7 - mode chosen from select bits
// RQ8 - core avoids flash during operation
// RQ9 - software keeps timing clock 257-476 kHz
// RQ10 - three sources, divided by divider field
// RQ11 - clock failure aborts, sets fail flag
// RQ12 - selected clock kept running while busy
// RQ13 - erased cells read one
// RQ14 - erase mode from mass and erase bits
// RQ15 - all-erase spares info memory when locked
// RQ16 - dummy write in range starts erase
// RQ17 - busy set right after dummy write
// RQ18 - done clears busy and erase bits
// RQ19 - erase length fixed
// RQ20 - out-of-range dummy write ignored silently
// RQ21 - flash-issued erase stalls core until done
// RQ22 - flash access during ram erase flags violation
// RQ23 - dummy write data discarded
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps

module fec_flash_erase_ctrl #(
    parameter logic [15:0] ERASE_FTG_CYC = fec_pkg::ERASE_FTG_DEF
) (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // core flash bus
    input  wire fec_pkg::fec_core_t core_in,
    output logic                    core_hold,
    // timing clock sources (asynchronous pins)
    input  wire logic               aux_clock,
    input  wire logic               sub_main_clock,
    input  wire logic               main_clock,
    // low-power handshake
    input  wire logic               lpm_clk_off_req,
    output logic                    src_clk_keep,
    // array control
    output logic                    read_mode,
    output logic                    ftg_run,
    output logic                    vgen_en,
    output fec_pkg::fec_erase_t     erase_cmd
);
    import fec_pkg::*;

    // =========================================================
    // functions
    // address inside [lo, hi]
    function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction

    // erase mode from mass and erase bits
    function automatic fec_emode_t emode(input logic mass, input logic ers);
        case ({mass, ers})
            2'b01:   emode = EM_SEG;
            2'b10:   emode = EM_MASS;
            2'b11:   emode = EM_ALL;
            default: emode = EM_NONE;
        endcase
    endfunction

    // =========================================================
    // state
    logic [3:0]  ctrl_q;          // select bits
    logic [7:0]  clkcfg_q;        // source and divider
    logic        lock_q;          // infoa_lock
    logic        fail_q;          // clock failure flag
    logic        avf_q;           // access_violation_flag
    fec_state_t  st_q;            // sequencer state
    logic        hold_q;          // core held
    logic [15:0] ftg_cnt_q;       // timing ticks elapsed
    logic [5:0]  div_cnt_q;       // divider count
    logic [10:0] fail_cnt_q;      // cycles since last source edge
    logic [2:0]  sync1_q;         // first synchroniser stage
    logic [2:0]  sync2_q;         // second synchroniser stage
    logic [2:0]  sync3_q;         // edge detect history
    fec_erase_t  ers_q;           // latched erase command
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        ftg_q;
    logic        vgen_q;
    logic        keep_q;
    logic        read_q;          // read mode, own flop for the pin

    // =========================================================
    // apb decode
    // pready_q masks the second edge, one answer per transfer
    wire         apb_acc   = psel && penable && !pready_q;
    wire         apb_done  = psel && penable && pready_q;
    wire         sel_ctrl  = (paddr == CTRL_OFS);
    wire         sel_clk   = (paddr == CLKCFG_OFS);
    wire         sel_stat  = (paddr == STAT_OFS);
    wire         mapped    = sel_ctrl || sel_clk || sel_stat;
    wire         wr_ctrl   = apb_done && pwrite && sel_ctrl;
    wire         wr_clk    = apb_done && pwrite && sel_clk;
    wire         wr_stat   = apb_done && pwrite && sel_stat;
    wire         busy      = (st_q == ST_ERASE);
    wire [31:0]  stat_rd   = {28'h0000000, avf_q, fail_q, lock_q, busy};
    wire [31:0]  rd_mux    = sel_ctrl ? {28'h0000000, ctrl_q} :
                             sel_clk  ? {24'h000000, clkcfg_q} :
                             sel_stat ? stat_rd : 32'h00000000;

    // =========================================================
    // timing generator source and divider
    wire [1:0]   src_sel   = clkcfg_q[SRC_LSB +: SRC_W];
    wire [5:0]   div_val   = clkcfg_q[DIV_LSB +: DIV_W];
    // one-cycle rising edges of the synchronised sources
    wire [2:0]   rise      = sync2_q & ~sync3_q;
    // pick one of three sources; unused code falls back to main clock
    wire         src_edge  = (src_sel == SRC_AUX) ? rise[0] :               // see RQ10
                             (src_sel == SRC_SUB) ? rise[1] : rise[2];
    // a tick each time the divider wraps on a source edge
    wire         ftg_tick  = busy && src_edge && (div_cnt_q == div_val);    // see RQ10
    // watchdog only while busy; a dead idle source is harmless
    wire         clk_fail  = busy && (fail_cnt_q == FAIL_CYC);              // see RQ11

    // =========================================================
    // erase start decode
    // the mode matters only in the dummy write cycle
    fec_emode_t  mode;
    assign mode = emode(ctrl_q[MASS_BIT], ctrl_q[ERASE_BIT]);               // see RQ7 see RQ14
    wire [15:0]  a         = core_in.addr;
    wire         in_info   = in_win(a, INFO_BASE, INFO_END);                // see RQ1
    wire         in_main   = in_win(a, MAIN_BASE, MAIN_END);
    wire         in_infoa  = in_win(a, INFOA_BASE, INFOA_BASE + INFO_SEG_SIZE - 16'h0001);
    // segment erase: any segment, the first info one only when unlocked
    wire         ok_seg    = (in_main || in_info) && !(in_infoa && lock_q); // see RQ3 see RQ4
    wire         in_range  = (mode == EM_SEG)  ? ok_seg :
                             (mode == EM_MASS) ? in_main :
                             (mode == EM_ALL)  ? (in_main || in_info) : 1'b0;
    // no start while busy: one erase at a time
    wire         dummy_wr  = !busy && core_in.acc && core_in.wr && (mode != EM_NONE);
    wire         start     = dummy_wr && in_range;                          // see RQ16
    // last tick of the fixed count ends the erase
    wire         done      = ftg_tick && (ftg_cnt_q == ERASE_FTG_CYC - 16'h0001); // see RQ19
    wire         finish    = done || clk_fail;
    // generators run from the start edge to the end edge
    wire         gen_on_d  = (st_q == ST_ERASE) ? !finish : start;
    wire [15:0]  seg_mask  = in_info ? INFO_SEG_MASK : MAIN_SEG_MASK;       // see RQ2

    // command for a new erase; the write data is never looked at
    fec_erase_t  ers_new;                                                   // see RQ23
    assign ers_new.seg      = (mode == EM_SEG);
    assign ers_new.seg_base = a & seg_mask;
    assign ers_new.main_all = (mode == EM_MASS) || (mode == EM_ALL);
    // info memory joins an all-erase only while unlocked
    assign ers_new.info_all = (mode == EM_ALL) && !lock_q;                  // see RQ15 see RQ3
    assign ers_new.infoa    = !lock_q && ((mode == EM_ALL) || ((mode == EM_SEG) && in_infoa));

    // flash access by the core while an unheld erase runs
    // a held core issues nothing, so only ram-started erases trip it
    wire         avf_set   = busy && !hold_q && core_in.acc;                // see RQ22
    wire         avf_clr   = wr_stat && pwdata[AVF_BIT];
    wire         fail_clr  = wr_stat && pwdata[FAIL_BIT];

    // =========================================================
    // synchronisers for the asynchronous clock sources
    // stage three is edge history; logic reads stages two and three only
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            sync3_q <= 3'h0;
        end else begin
            sync1_q <= {main_clock, sub_main_clock, aux_clock};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // =========================================================
    // apb slave: one wait state, answer registered
    // unmapped addresses answer pslverr and zero data
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= apb_acc;
            prdata_q  <= (apb_acc && !pwrite) ? rd_mux : 32'h00000000;
            pslverr_q <= apb_acc && !mapped;
        end
    end

    // =========================================================
    // configuration registers
    // writes while busy are dropped without error
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_q   <= CTRL_RST;
            clkcfg_q <= CLKCFG_RST;
        end else begin
            // completion or abort clears the erase selects
            if (finish) begin
                ctrl_q[MASS_BIT]  <= 1'b0;                                  // see RQ18
                ctrl_q[ERASE_BIT] <= 1'b0;
            end else if (wr_ctrl && !busy) begin
                ctrl_q <= pwdata[3:0];
            end
            // divider and source frozen while busy
            if (wr_clk && !busy) begin
                clkcfg_q <= pwdata[7:0];
            end
        end
    end

    // =========================================================
    // status flags; a set wins over a clear in the same cycle
    // software keeps the lock still while erasing
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            lock_q <= LOCK_RST;
            fail_q <= 1'b0;
            avf_q  <= 1'b0;
        end else begin
            // a one toggles, a zero leaves it
            if (wr_stat && pwdata[LOCK_BIT]) begin
                lock_q <= !lock_q;                                          // see RQ5
            end
            fail_q <= clk_fail || (fail_q && !fail_clr);                    // see RQ11
            avf_q  <= avf_set || (avf_q && !avf_clr);                       // see RQ22
        end
    end

    // =========================================================
    // erase sequencer
    // fetch bit of the dummy write decides the core stall
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_q   <= ST_IDLE;
            hold_q <= 1'b0;
            ers_q  <= '0;
        end else begin
            case (st_q)
                // read mode; out-of-range dummy writes fall through silently
                ST_IDLE: begin
                    if (start) begin
                        st_q   <= ST_ERASE;                                 // see RQ17
                        hold_q <= core_in.fetch;                            // see RQ21
                        ers_q  <= ers_new;                                  // see RQ20
                    end
                end
                // erasing until the fixed tick count or a clock failure
                ST_ERASE: begin
                    if (finish) begin
                        st_q   <= ST_IDLE;                                  // see RQ18 see RQ11
                        hold_q <= 1'b0;                                     // see RQ21
                        ers_q  <= '0;
                    end
                end
                default: begin
                    st_q   <= ST_IDLE;
                    hold_q <= 1'b0;
                    ers_q  <= '0;
                end
            endcase
        end
    end

    // =========================================================
    // timing generator counters
    // cleared while idle, so each erase counts from zero
    always_ff @(posedge ref_clk) begin
        if (!rstn || !busy) begin
            div_cnt_q  <= 6'h00;
            ftg_cnt_q  <= 16'h0000;
            fail_cnt_q <= 11'h000;
        end else begin
            // divide selected source by divider field plus one
            if (src_edge) begin
                div_cnt_q <= (div_cnt_q == div_val) ? 6'h00 : div_cnt_q + 6'h01;
            end
            if (ftg_tick) begin
                ftg_cnt_q <= ftg_cnt_q + 16'h0001;                          // see RQ19
            end
            // watchdog on the selected source
            fail_cnt_q <= src_edge ? 11'h000 : fail_cnt_q + 11'h001;        // see RQ11
        end
    end

    // =========================================================
    // generator enables and clock keep-alive
    // read mode has its own flop so the pin is registered
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ftg_q  <= 1'b0;
            vgen_q <= 1'b0;
            keep_q <= 1'b1;
            read_q <= 1'b1;
        end else begin
            ftg_q  <= gen_on_d;                                             // see RQ6
            vgen_q <= gen_on_d;                                             // see RQ6
            read_q <= !gen_on_d;                                            // see RQ6
            // low power cannot stop the source from start to end
            keep_q <= !lpm_clk_off_req || start || (busy && !finish);       // see RQ12
        end
    end

    // =========================================================
    // outputs; an erase drives every cell of its range to one
    assign pready    = pready_q;
    assign prdata    = prdata_q;
    assign pslverr   = pslverr_q;
    assign core_hold = hold_q;
    assign ftg_run   = ftg_q;
    assign vgen_en   = vgen_q;
    assign read_mode = read_q;
    assign src_clk_keep = keep_q;
    assign erase_cmd = ers_q;                                               // see RQ13

    // =========================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_busy_after_start:   assert property (start |=> busy && vgen_en)       // see RQ17
        else $error("busy not set after dummy write");
    a_busy_holds:         assert property (busy && !finish |=> busy)        // see RQ17
        else $error("busy dropped early");
    a_done_clears:        assert property (finish |=> !busy && !ctrl_q[MASS_BIT] && !ctrl_q[ERASE_BIT]) // see RQ18
        else $error("done did not clear busy or selects");
    a_ignore_outside:     assert property (dummy_wr && !in_range |=> !busy && $stable(avf_q) && $stable(fail_q)) // see RQ20
        else $error("out of range dummy write acted");
    a_lock_toggle:        assert property (wr_stat && pwdata[LOCK_BIT] |=> lock_q != $past(lock_q)) // see RQ5
        else $error("lock did not toggle");
    a_idle_gens_off:      assert property (!busy && !start |=> !vgen_en && !ftg_run) // see RQ6
        else $error("generators wrong around idle");
    a_fail_aborts:        assert property (clk_fail |=> fail_q && !busy && !vgen_en ##1 !vgen_en) // see RQ11
        else $error("clock failure did not abort");
    a_avf_set:            assert property (avf_set |=> avf_q)               // see RQ22
        else $error("violation flag not set");
    a_infoa_locked:       assert property (lock_q && busy |-> !erase_cmd.infoa && !erase_cmd.info_all) // see RQ3
        else $error("locked info segment in erase");
    a_hold_busy:          assert property (core_hold |-> busy)              // see RQ21
        else $error("core held while idle");
    // keep-alive, read mode, command and bus checks
    a_keep_busy:  assert property (busy |-> src_clk_keep) // see RQ12
        else $error("source released while busy");
    a_read_mode:  assert property (read_mode != vgen_en) // see RQ6
        else $error("read mode overlaps generator");
    a_idle_cmd:   assert property (!busy |-> erase_cmd == '0) // see RQ6
        else $error("erase command while idle");
    a_cmd_stable: assert property (busy && !finish |=> $stable(erase_cmd)) // see RQ16
        else $error("erase command changed mid-erase");
    a_apb_once:   assert property (pready |=> !pready)
        else $error("ready held two cycles");

    c_erase_done:  cover property (busy ##1 done ##1 !busy);
    c_erase_abort: cover property (clk_fail);
    c_ignored_wr:  cover property (dummy_wr && !in_range);
    c_fetch_hold:  cover property (start && core_in.fetch);
    c_violation:   cover property (avf_set);
endmodule

// ===== rtl/fec_pkg.sv
// package of constants and types for the flash erase controller
package fec_pkg;

    // =========================================================
    // register map (apb byte addresses)
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] CLKCFG_OFS = 12'h004;
    localparam logic [11:0] STAT_OFS   = 12'h008;

    // ctrl fields
    localparam int ERASE_BIT     = 0;
    localparam int MASS_BIT      = 1;
    localparam int WRITE_BIT     = 2;
    localparam int BLKWR_BIT     = 3;
    // clock config fields
    localparam int DIV_LSB       = 0;
    localparam int DIV_W         = 6;
    localparam int SRC_LSB       = 6;
    localparam int SRC_W         = 2;
    // status fields
    localparam int BUSY_BIT      = 0;
    localparam int LOCK_BIT      = 1;
    localparam int FAIL_BIT      = 2;
    localparam int AVF_BIT       = 3;

    // reset values
    localparam logic [3:0]  CTRL_RST   = 4'h0;
    localparam logic [7:0]  CLKCFG_RST = 8'h00;
    localparam logic        LOCK_RST   = 1'b1;

    // =========================================================
    // flash address map
    localparam int          FA_W          = 16;
    localparam logic [15:0] INFO_SEG_SIZE = 16'h0040;  // 64-byte info segments
    localparam logic [15:0] MAIN_SEG_SIZE = 16'h0200;  // 512-byte main segments
    localparam logic [15:0] INFO_BASE     = 16'h1000;
    localparam logic [15:0] INFO_END      = 16'h10ff;  // four info segments
    localparam logic [15:0] MAIN_BASE     = 16'hc000;
    localparam logic [15:0] MAIN_END      = 16'hffff;
    localparam logic [15:0] INFOA_BASE    = 16'h1000;  // info_segment_first
    localparam logic [15:0] INFO_SEG_MASK = 16'hffc0;
    localparam logic [15:0] MAIN_SEG_MASK = 16'hfe00;

    // =========================================================
    // timing
    localparam int          CLK_MHZ       = 125;
    localparam int          FAIL_NS       = 8000;      // no source edge for this long is a failure
    localparam int          FAIL_CYC_I    = (FAIL_NS * CLK_MHZ) / 1000;
    localparam logic [10:0] FAIL_CYC      = 11'(FAIL_CYC_I);
    localparam logic [15:0] ERASE_FTG_DEF = 16'h12c0;  // erase length in timing-generator ticks

    // clock source codes
    localparam logic [1:0] SRC_AUX  = 2'h0;
    localparam logic [1:0] SRC_SUB  = 2'h1;
    localparam logic [1:0] SRC_MAIN = 2'h2;

    // erase modes
    typedef enum logic [3:0] {
        EM_NONE = 4'h1,
        EM_SEG  = 4'h2,
        EM_MASS = 4'h4,
        EM_ALL  = 4'h8
    } fec_emode_t;

    // controller states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h1,
        ST_ERASE = 2'h2
    } fec_state_t;

    // erase command towards the array
    typedef struct packed {
        logic        main_all;   // erase every main segment
        logic        info_all;   // erase info memory (first segment included only when unlocked)
        logic        infoa;      // first info segment takes part
        logic        seg;        // erase one segment
        logic [15:0] seg_base;   // base of that segment
    } fec_erase_t;

    // core flash access
    typedef struct packed {
        logic        acc;        // any read or write to flash
        logic        wr;         // write
        logic        fetch;      // the access is issued by code running from flash
        logic [15:0] addr;
    } fec_core_t;

endpackage

// ===== bench/fec_core_model.sv
// behavioural model of the processor core on the flash bus
`timescale 1ns/100ps
module fec_core_model (
    // clock
    input  wire logic               ref_clk,
    // flash bus
    input  wire logic               core_hold,
    output fec_pkg::fec_core_t      core_in
);
    import fec_pkg::*;

    // =========================================================
    // bus idles with no access pending
    initial core_in = '0;

    // one access cycle; the bench asks for flash during an erase only on purpose
    task access(input logic [15:0] a, input logic w, input logic f);
        // a held core is frozen until the hold drops
        while (core_hold === 1'b1) @(posedge ref_clk);
        core_in <= '{acc: 1'b1, wr: w, fetch: f, addr: a};
        @(posedge ref_clk);
        // released bus shows no stale address
        core_in <= '{acc: 1'b0, wr: !w, fetch: !f, addr: ~a};
    endtask
endmodule

// ===== bench/test_fec_flash_erase_ctrl.sv
// self-checking testbench for the flash erase controller
`timescale 1ns/100ps
module test_fec_flash_erase_ctrl;
    import fec_pkg::*;

    // =========================================================
    // stimulus and observed signals
    logic        ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, lpm_clk_off_req = 0;
    logic        aux_clock = 0, sub_main_clock = 0, main_clock = 0, err;
    logic [11:0] paddr   = '0;
    logic [31:0] pwdata  = '0, prdata, rd;
    logic        pready, pslverr, core_hold, src_clk_keep, read_mode, ftg_run, vgen_en;
    fec_core_t   core_in;
    fec_erase_t  erase_cmd;
    int          n_mismatch = 0, checks = 0, t_seg, t_all, t_div;

    // clocks; the auxiliary source stays still so it can fail
    always #4 ref_clk = ~ref_clk;
    always #12 main_clock = ~main_clock;
    always #20 sub_main_clock = ~sub_main_clock;

    fec_flash_erase_ctrl #(.ERASE_FTG_CYC(16'h0004)) i_dut (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .core_in(core_in), .core_hold(core_hold), .aux_clock(aux_clock),
        .sub_main_clock(sub_main_clock), .main_clock(main_clock),
        .lpm_clk_off_req(lpm_clk_off_req), .src_clk_keep(src_clk_keep), .read_mode(read_mode),
        .ftg_run(ftg_run), .vgen_en(vgen_en), .erase_cmd(erase_cmd));
    fec_core_model i_core (.ref_clk(ref_clk), .core_hold(core_hold), .core_in(core_in));

    // =========================================================
    // counted comparison
    task chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    // one apb transfer, entered right after a rising edge; result in rd and err
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        chk(n == 2, "apb wait states");
        psel <= 1'b0; penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    // program selects, dummy write, judge start and end; v adds a flash read while busy
    task erase(input logic [3:0] c, input logic [15:0] a, input logic f, input logic v, input logic go,
               input logic [3:0] m, input logic [3:0] e, output int n);
        apb(1'b1, CTRL_OFS, {28'h0, c});
        i_core.access(a, 1'b1, f);
        #1;
        chk(ftg_run === go && vgen_en === go && read_mode === !go, "start state");
        chk(core_hold === (go & f) && src_clk_keep === (go | !lpm_clk_off_req), "hold or keep");
        if (go) chk((erase_cmd[19:16] & m) === e, "erase mode");
        if (go && e[0]) chk(erase_cmd.seg_base === (a & (a >= MAIN_BASE ? MAIN_SEG_MASK : INFO_SEG_MASK)), "base");
        if (v) begin
            @(posedge ref_clk);
            i_core.access(16'hc100, 1'b0, 1'b0);
        end
        @(posedge ref_clk);
        n = 1;
        while (ftg_run !== 1'b0 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        chk(n < 3000 && core_hold === 1'b0 && vgen_en === 1'b0 && read_mode === 1'b1, "no end");
        apb(1'b0, CTRL_OFS, 32'h0);
        if (go) chk(rd[1:0] === 2'b00, "selects kept");
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd[BUSY_BIT] === 1'b0, "busy kept");
    endtask

    // =========================================================
    // scenarios
    task t_reset;
        chk(read_mode === 1'b1 && ftg_run === 1'b0 && vgen_en === 1'b0 && src_clk_keep === 1'b1, "idle");
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd === {30'h0, LOCK_RST, 1'b0}, "status reset");
        apb(1'b0, 12'h00c, 32'h0);
        chk(err === 1'b1 && rd === 32'h0, "unmapped");
    endtask

    task t_lock;
        apb(1'b1, STAT_OFS, 32'h2);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd[LOCK_BIT] === 1'b0, "lock toggle");
        apb(1'b1, STAT_OFS, 32'h0);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd[LOCK_BIT] === 1'b0, "zero write");
        apb(1'b1, STAT_OFS, 32'h2);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd[LOCK_BIT] === 1'b1, "lock back");
    endtask

    task t_modes;
        int n;
        apb(1'b1, CLKCFG_OFS, 32'h80);
        erase(4'h1, 16'hfc10, 1'b0, 1'b0, 1'b1, 4'hf, 4'b0001, t_seg);
        erase(4'h1, 16'h1010, 1'b0, 1'b0, 1'b0, 4'hf, 4'h0, n);
        erase(4'h1, 16'h2000, 1'b0, 1'b0, 1'b0, 4'hf, 4'h0, n);
        chk(rd[3:2] === 2'b00, "flag on ignored write");
        erase(4'h2, 16'h1000, 1'b0, 1'b0, 1'b0, 4'hf, 4'h0, n);
        erase(4'h2, 16'hc000, 1'b0, 1'b0, 1'b1, 4'b1001, 4'b1000, n);
        erase(4'h3, 16'hc000, 1'b0, 1'b0, 1'b1, 4'hf, 4'b1000, n);
        apb(1'b1, STAT_OFS, 32'h2);
        erase(4'h3, 16'h1000, 1'b0, 1'b0, 1'b1, 4'hf, 4'b1110, t_all);
        chk(t_all <= t_seg + 4 && t_seg <= t_all + 4, "length varies");
        erase(4'h1, 16'h1010, 1'b0, 1'b0, 1'b1, 4'b1101, 4'b0001, n);
        apb(1'b1, STAT_OFS, 32'h2);
    endtask

    task t_hold;
        int n;
        lpm_clk_off_req <= 1'b1;
        erase(4'h1, 16'hfe00, 1'b1, 1'b0, 1'b1, 4'hf, 4'b0001, n);
        #1;
        chk(src_clk_keep === 1'b0, "source kept after end");
        @(posedge ref_clk);
        lpm_clk_off_req <= 1'b0;
    endtask

    task t_viol;
        int n;
        erase(4'h1, 16'hfc10, 1'b0, 1'b1, 1'b1, 4'hf, 4'b0001, n);
        chk(rd[AVF_BIT] === 1'b1, "no violation");
        apb(1'b1, STAT_OFS, 32'h8);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd[AVF_BIT] === 1'b0, "violation stuck");
    endtask

    task t_clk;
        int n;
        apb(1'b1, CLKCFG_OFS, 32'h43);
        erase(4'h1, 16'hfc10, 1'b0, 1'b0, 1'b1, 4'hf, 4'b0001, t_div);
        chk(t_div > 3 * t_seg, "divider unused");
        apb(1'b1, CLKCFG_OFS, 32'h00);
        erase(4'h1, 16'hfc10, 1'b0, 1'b0, 1'b1, 4'hf, 4'b0001, n);
        chk(rd[FAIL_BIT] === 1'b1 && n > 900, "no failure");
        apb(1'b1, STAT_OFS, 32'h4);
    endtask

    // =========================================================
    // verdict and end of run
    task summarize;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_lock();
        t_modes();
        t_hold();
        t_viol();
        t_clk();
        summarize();
    end

    // watchdog against a hang
    initial begin
        #400000;
        n_mismatch++;
        summarize();
    end
endmodule
